// ==== bench/display_memory_bus_glue_bench.sv ====
// Self-checking bench for the display memory bus glue.
// Assumes the region codes of the design header.
`include "dmb_glue_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module display_memory_bus_glue_bench;
  logic        clk = 1'b0, rstn = 1'b0, ale = 1'b0, rd_n = 1'b1;
  logic        wr_n = 1'b1, go = 1'b0, column_mode_select = 1'b0;
  logic        program_store_enable_n = 1'b1, char_clk;
  logic        video_bus_request, memory_bus_grant, char_ram_en_ff;
  logic        serial_en_ff, video_ctl_en_ff, program_mem_en_ff;
  logic        disp_from_video_ff, font_we_ff, font_ready_ff;
  logic        osc80_en_ff, osc132_en_ff;
  logic [1:0]  host_font_sel = 2'h0, font_sel_ff, host_font_ff;
  logic [7:0]  ad_in = 8'h00, addr_hi = 8'h00, font_src_data = 8'h00;
  logic [7:0]  char_ram_rdata = 8'h00, attr_ram_rdata = 8'h00, hi;
  logic [7:0]  addr_lo_ff, char_latch_ff, attr_latch_ff, font_wdata_ff;
  logic [12:0] row_addr = 13'h0000, video_addr, disp_addr_ff;
  logic [12:0] font_addr_ff;
  logic [7:0]  ch = 8'h00, at = 8'h00;
  int          error_cnt = 0, checks = 0, cyc = 0, n;
  display_memory_bus_glue display_memory_bus_glue_inst (.*);
  video_ctl_model video_ctl_model_inst (.*);
  always #2 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [2:0] dec(input logic [7:0] a);
    return {a[7:5] == `DEC_CHAR_RAM, a[7:5] == `DEC_SERIAL,
            a[7:5] == `DEC_VIDEO_CTL};
  endfunction
  // Address phase, then one read or write strobe
  task automatic host(input logic [7:0] lo, input logic wr);
    addr_hi = hi;
    ad_in = lo;
    ale = 1'b1;
    repeat (2) @(negedge clk);
    ale = 1'b0;
    repeat (3) @(negedge clk);
    ad_in = ~lo;
    rd_n = wr;
    wr_n = !wr;
    repeat (4) @(negedge clk);
    chk(addr_lo_ff, lo);
    chk(dec(hi), {char_ram_en_ff, serial_en_ff, video_ctl_en_ff});
    rd_n = 1'b1;
    wr_n = 1'b1;
    @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      stop_test;
    end
  end
  initial
  begin
    n = $urandom(93);
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    n = 0;
    while (font_ready_ff !== 1'b1)
    begin
      font_src_data = 8'($urandom);
      @(negedge clk);
      chk(font_addr_ff, 16'(n));
      chk(font_wdata_ff, font_src_data);
      n += int'(font_we_ff);
    end
    chk(16'(n), 16'd8192);
    $display("font load test done");
    for (int i = 0; i < 24; i++)
    begin
      column_mode_select = 1'($urandom);
      program_store_enable_n = 1'($urandom);
      host_font_sel = 2'($urandom);
      hi = 8'($urandom);
      if (i < 8)
        hi[7:5] = 3'(i);
      host(8'($urandom), 1'($urandom));
      chk(program_mem_en_ff, !program_store_enable_n);
      chk({osc132_en_ff, osc80_en_ff}, {column_mode_select,
          !column_mode_select});
      chk(host_font_ff, host_font_sel);
    end
    $display("host bus test done");
    char_ram_rdata = 8'($urandom);
    attr_ram_rdata = 8'($urandom);
    row_addr = 13'($urandom);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    n = 0;
    repeat (100)
    begin
      @(negedge clk);
      if (disp_from_video_ff === 1'b1)
      begin
        n++;
        chk(disp_addr_ff, row_addr);
        // New data per fill cycle; second entry is shown last
        char_ram_rdata = 8'($urandom);
        attr_ram_rdata = 8'($urandom);
        if (n == 2)
        begin
          ch = char_ram_rdata;
          at = attr_ram_rdata;
        end
      end
    end
    chk(16'(n), 16'd20);
    chk(char_latch_ff, ch);
    chk(attr_latch_ff, at);
    chk(font_sel_ff, at[7:6]);
    $display("video transfer test done");
    stop_test;
  end
endmodule // display_memory_bus_glue_bench
`default_nettype wire

// ==== bench/glue_props.sv ====
// Checker for the display memory bus glue ports.
// Assumes binding onto the design top.
`timescale 1ns/1ps
`default_nettype none
module glue_props
(
  // Inputs
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [7:0] addr_hi,
  input wire logic       program_store_enable_n,
  input wire logic       column_mode_select,
  input wire logic       video_bus_request,
  input wire logic       memory_bus_grant,
  // Outputs
  input wire logic       char_ram_en_ff,
  input wire logic       serial_en_ff,
  input wire logic       video_ctl_en_ff,
  input wire logic       program_mem_en_ff,
  input wire logic       disp_from_video_ff,
  input wire logic       osc80_en_ff,
  input wire logic       osc132_en_ff,
  input wire logic       font_we_ff,
  input wire logic       font_ready_ff
);
  wire       own = video_bus_request | memory_bus_grant;
  wire [2:0] en = {char_ram_en_ff, serial_en_ff, video_ctl_en_ff};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_acc(r);
    (!(rd_n & wr_n) && addr_hi[7:5] == r && !own)[*4];
  endsequence
  property p_excl; $onehot0(en); endproperty
  property p_own; own[*4] |-> en == 3'h0; endproperty
  property p_char; s_acc(3'h0) |-> char_ram_en_ff; endproperty
  property p_ser; s_acc(3'h1) |-> serial_en_ff; endproperty
  property p_prog;
    $stable(program_store_enable_n)[*4]
      |-> program_mem_en_ff != program_store_enable_n;
  endproperty
  property p_osc;
    $stable(column_mode_select)[*4] |-> osc132_en_ff == column_mode_select
      && osc80_en_ff != column_mode_select;
  endproperty
  property p_fill;
    (video_bus_request && memory_bus_grant && rd_n && wr_n)[*4]
      |-> disp_from_video_ff;
  endproperty
  property p_nofill; (!memory_bus_grant)[*4] |-> !disp_from_video_ff;
  endproperty
  property p_font;
    font_ready_ff && $past(font_ready_ff) |-> !font_we_ff;
  endproperty
  a_excl: assert property (p_excl) else $error("enables overlap");
  a_own: assert property (p_own) else $error("enable in video");
  a_char: assert property (p_char) else $error("no char en");
  a_ser: assert property (p_ser) else $error("no serial en");
  a_prog: assert property (p_prog) else $error("program en");
  a_osc: assert property (p_osc) else $error("osc select");
  a_fill: assert property (p_fill) else $error("no fill");
  a_nofill: assert property (p_nofill) else $error("early fill");
  a_font: assert property (p_font) else $error("font write late");
endmodule // glue_props
bind display_memory_bus_glue glue_props glue_props_inst (.*);
`default_nettype wire

// ==== bench/video_ctl_model.sv ====
// Video timing controller model: request, grant, char clock.
// Assumes go is raised for one cycle by the bench.
`timescale 1ns/1ps
`default_nettype none
module video_ctl_model
(
  // Control
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [12:0] row_addr,
  // Video bus
  output logic             video_bus_request,
  output logic             memory_bus_grant,
  output logic [12:0]      video_addr,
  output logic             char_clk
);
  initial
  begin
    video_bus_request = 1'b0;
    memory_bus_grant = 1'b0;
    video_addr = 13'h1555;
    char_clk = 1'b0;
  end
  always @(posedge clk)
    if (go && !video_bus_request)
    begin
      @(negedge clk);
      video_addr = row_addr;
      repeat (4) @(negedge clk);
      video_bus_request = 1'b1;
      repeat (40) @(negedge clk);
      memory_bus_grant = 1'b1;
      repeat (20) @(negedge clk);
      memory_bus_grant = 1'b0;
      video_bus_request = 1'b0;
      video_addr = ~row_addr;
      repeat (4)
      begin
        repeat (4) @(negedge clk);
        char_clk = ~char_clk;
      end
    end
endmodule // video_ctl_model
`default_nettype wire

// ==== design/display_memory_bus_glue.v ====
// Bus glue between host microcontroller, display RAMs, row buffers,
// font RAM and dot clock oscillators.
// Assumes all host and video controller pins are asynchronous to clk.
// Behaviour
// - Latch low address byte on falling ALE
// - Decode A13-A15 with strobes to enables
// - Program memory enabled only by program strobe
// - Video address held until request and release
// - Route video address to both display RAMs
// - Two 8Kx8 RAMs: characters and attributes
// - Character access also addresses attribute location
// - Row buffers hold row characters and attributes
// - One-character latch feeds character generator
// - Attribute bits select one of four fonts
// - Load font RAM at power-on
// - Column mode selects dot clock oscillator
// - Request precedes grant; grant moves row
`include "dmb_glue_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module display_memory_bus_glue
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Host bus
  input  wire        ale,
  input  wire [7:0]  ad_in,
  input  wire [7:0]  addr_hi,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire        program_store_enable_n,
  input  wire        column_mode_select,
  input  wire [1:0]  host_font_sel,
  // Video timing controller
  input  wire        video_bus_request,
  input  wire        memory_bus_grant,
  input  wire [12:0] video_addr,
  input  wire        char_clk,
  // Font pattern source for power-on load
  input  wire [7:0]  font_src_data,
  // Display RAM data returned
  input  wire [7:0]  char_ram_rdata,
  input  wire [7:0]  attr_ram_rdata,
  // Decoded enables
  output reg         char_ram_en_ff,
  output reg         serial_en_ff,
  output reg         video_ctl_en_ff,
  output reg         program_mem_en_ff,
  // Display RAM address, shared by character and attribute RAMs
  output reg  [12:0] disp_addr_ff,
  output reg         disp_from_video_ff,
  output reg  [7:0]  addr_lo_ff,
  // Character generator side
  output reg  [7:0]  char_latch_ff,
  output reg  [7:0]  attr_latch_ff,
  output reg  [1:0]  font_sel_ff,
  output reg  [1:0]  host_font_ff,
  // Font RAM load
  output reg         font_we_ff,
  output reg  [12:0] font_addr_ff,
  output reg  [7:0]  font_wdata_ff,
  output reg         font_ready_ff,
  // Oscillator enables
  output reg         osc80_en_ff,
  output reg         osc132_en_ff
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam SW = 39;
  wire [SW-1:0] async_in = {ale, ad_in, addr_hi, rd_n, wr_n,
                            program_store_enable_n, column_mode_select,
                            host_font_sel, video_bus_request,
                            memory_bus_grant, video_addr, char_clk};
  reg  [SW-1:0] sync1_ff;
  reg  [SW-1:0] sync2_ff;
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      // Idle levels, so no false strobe follows reset
      sync1_ff <= `SYNC_IDLE;
      sync2_ff <= `SYNC_IDLE;
    end
    else
    begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end
  wire        s_ale   = sync2_ff[38];
  wire [7:0]  s_ad    = sync2_ff[37:30];
  wire [7:0]  s_ahi   = sync2_ff[29:22];
  wire        s_rd_n  = sync2_ff[21];
  wire        s_wr_n  = sync2_ff[20];
  wire        s_pse_n = sync2_ff[19];
  wire        s_col   = sync2_ff[18];
  wire [1:0]  s_hfont = sync2_ff[17:16];
  wire        s_video_bus_request  = sync2_ff[15];
  wire        s_grant = sync2_ff[14];
  wire [12:0] s_vaddr = sync2_ff[13:1];
  wire        s_cclk  = sync2_ff[0];
  // Upper address needs no latch, low byte comes from the latch
  wire [15:0] host_addr = {s_ahi, addr_lo_ff};

  // ****************************************
  // Address latch and decode
  // ****************************************
  reg        ale_d_ff;
  reg [12:0] vaddr_hold_ff;
  wire       video_owns = s_video_bus_request | s_grant;
  wire [2:0] region = host_addr[15:13];
  wire       strobe = ~s_rd_n | ~s_wr_n;
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      ale_d_ff          <= 1'b0;
      addr_lo_ff        <= 8'h00;
      char_ram_en_ff    <= 1'b0;
      serial_en_ff      <= 1'b0;
      video_ctl_en_ff   <= 1'b0;
      program_mem_en_ff <= 1'b0;
      vaddr_hold_ff     <= 13'h0000;
      disp_addr_ff      <= 13'h0000;
      disp_from_video_ff <= 1'b0;
    end
    else
    begin
      ale_d_ff <= s_ale;
      // Capture on falling ALE, hold while data follows
      if (ale_d_ff && !s_ale)
        addr_lo_ff <= s_ad;
      // Data-space decode, exclusive, off during video ownership
      char_ram_en_ff  <= strobe && !video_owns &&
                         region == `DEC_CHAR_RAM;
      serial_en_ff    <= strobe && !video_owns && region == `DEC_SERIAL;
      video_ctl_en_ff <= strobe && !video_owns &&
                         region == `DEC_VIDEO_CTL;
      // Program memory only from its own strobe
      program_mem_en_ff <= ~s_pse_n;
      // Hold video address while host may still own the bus
      if (!s_video_bus_request)
        vaddr_hold_ff <= s_vaddr;
      // Drive video address only after request and grant
      if (s_video_bus_request && s_grant && !strobe)
      begin
        disp_addr_ff       <= vaddr_hold_ff;
        disp_from_video_ff <= 1'b1;
      end
      else
      begin
        // One address serves both RAMs: 16-bit char+attr word
        disp_addr_ff       <= host_addr[`DISP_ADDR_W-1:0];
        disp_from_video_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Row buffers and character latch
  // ****************************************
  reg [7:0] row_char_mem [0:`ROW_DEPTH-1];
  reg [7:0] row_attr_mem [0:`ROW_DEPTH-1];
  reg [7:0] wr_ptr_ff;
  reg [7:0] rd_ptr_ff;
  reg       cclk_d_ff;
  reg       grant_d_ff;
  wire      cclk_rise = s_cclk & ~cclk_d_ff;
  // Fill in display order while grant moves the row
  always @(posedge clk)
  begin
    if (disp_from_video_ff)
    begin
      row_char_mem[wr_ptr_ff] <= char_ram_rdata;
      row_attr_mem[wr_ptr_ff] <= attr_ram_rdata;
    end
  end
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_ptr_ff     <= 8'h00;
      rd_ptr_ff     <= 8'h00;
      cclk_d_ff     <= 1'b0;
      grant_d_ff    <= 1'b0;
      char_latch_ff <= 8'h00;
      attr_latch_ff <= 8'h00;
      font_sel_ff   <= 2'h0;
      host_font_ff  <= 2'h0;
    end
    else
    begin
      cclk_d_ff  <= s_cclk;
      grant_d_ff <= s_grant;
      if (s_grant && !grant_d_ff)
        wr_ptr_ff <= 8'h00;
      else if (disp_from_video_ff)
        wr_ptr_ff <= wr_ptr_ff + 8'h01;
      if (s_grant && !grant_d_ff)
        rd_ptr_ff <= 8'h00;
      else if (cclk_rise)
      begin
        // One character held until the next
        char_latch_ff <= row_char_mem[rd_ptr_ff];
        attr_latch_ff <= row_attr_mem[rd_ptr_ff];
        // Font from attribute bits
        font_sel_ff   <= row_attr_mem[rd_ptr_ff]
                         [`FONT_SEL_MSB:`FONT_SEL_LSB];
        rd_ptr_ff     <= rd_ptr_ff + 8'h01;
      end
      host_font_ff <= s_hfont;
    end
  end

  // ****************************************
  // Power-on font load and oscillator select
  // ****************************************
  reg [13:0] font_cnt_ff;
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      font_cnt_ff   <= 14'h0000;
      font_we_ff    <= 1'b0;
      font_addr_ff  <= 13'h0000;
      font_wdata_ff <= 8'h00;
      font_ready_ff <= 1'b0;
      osc80_en_ff   <= 1'b0;
      osc132_en_ff  <= 1'b0;
    end
    else
    begin
      // Walk every font location once after reset
      if (!font_ready_ff)
      begin
        font_we_ff    <= 1'b1;
        font_addr_ff  <= font_cnt_ff[`FONT_ADDR_W-1:0];
        font_wdata_ff <= font_src_data;
        font_cnt_ff   <= font_cnt_ff + 14'h0001;
        if (font_cnt_ff == `FONT_LAST)
          font_ready_ff <= 1'b1;
      end
      else
        font_we_ff <= 1'b0;
      // Exactly one oscillator enabled out of reset; reset clears both
      osc80_en_ff  <= (s_col == `COL_MODE_80);
      osc132_en_ff <= (s_col != `COL_MODE_80);
    end
  end

endmodule // display_memory_bus_glue

`default_nettype wire

// ==== design/dmb_glue_regs.vh ====
// Constants for the display memory bus glue block.
// Assumes inclusion by bare name from the design module.
`ifndef DMB_GLUE_REGS_VH
`define DMB_GLUE_REGS_VH

// Host address fields
`define ADDR_HI_W        8
`define ADDR_LO_W        8
`define DEC_MSB          7
`define DEC_LSB          5
`define DISP_ADDR_W      13
// Synchroniser reset: active-low host strobes start idle high
`define SYNC_IDLE        39'h00380000
// Decoded regions on A15..A13
`define DEC_CHAR_RAM     3'h0
`define DEC_SERIAL       3'h1
`define DEC_VIDEO_CTL    3'h2
// Attribute font select field
`define FONT_SEL_MSB     7
`define FONT_SEL_LSB     6
`define FONT_ADDR_W      13
`define FONT_CNT_W       14
`define FONT_LAST        14'h1FFF
// Row buffer
`define ROW_ADDR_W       8
`define ROW_DEPTH        256
// Dot clock oscillators: 0 = 80 columns, 1 = 132 columns
`define COL_MODE_80      1'b0

`endif
